// file: design/csi_pkg.sv
// Types shared by the serial port modules
package csi_pkg;
   typedef enum logic [1:0] {
      CLK_EXT    = 2'b00,
      CLK_BAUD   = 2'b01,
      CLK_DIV32  = 2'b10,
      CLK_DIV8   = 2'b11
   } clk_sel_t;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_ACK   = 2'b10
   } xfer_state_t;
endpackage : csi_pkg

// file: design/csi_regs.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef CSI_REGS_SVH
`define CSI_REGS_SVH
`define MODE_CTRL_ADDR   16'hff80
`define SHIFT_DATA_ADDR  16'hff84
`define BUS_CTRL_ADDR    16'hff88
`define MODE_CTRL_RESET  8'h00
`define BUS_CTRL_RESET   8'h00
`define SHIFT_RESET      8'h00
// Mode control fields
`define BIT_TX_EN        7
`define BIT_RX_EN        6
`define BIT_WAKEUP       5
`define BIT_PIN_CHOICE   4
`define BIT_MODE_HI      3
`define BIT_MODE_LO      2
// Bus control fields
`define BIT_REL_TRIG     0
`define BIT_CMD_TRIG     1
`define BIT_REL_SEEN     2
`define BIT_CMD_SEEN     3
`define BIT_ACK_EN       4
`define BIT_ACK_SEEN     5
`define BIT_DONE_FLAG    6
`define BIT_BUSY_EN      7
`define BIT_LINE_LEVEL   8
// Half periods of the internal shift clock, in system clocks minus one
`define DIV32_HALF       5'd15
`define DIV8_HALF        5'd3
`define LAST_BIT         3'd7
// Vector table entries of the transfer-done interrupt
`define VEC_PAGE0        16'h0022
`define VEC_PAGE1        16'h8022
`define MACRO_WORD_ADDR  16'hfe22
`endif

// file: design/csi_top.sv
// Clocked serial port: three-wire and two-wire bus modes behind a Wishbone slave
`timescale 1ns/1ps
`include "csi_regs.svh"
module csi_top
   import csi_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [15:0] adr_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   input  wire logic        baud_tick_i,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   input  wire logic        pin_a_i,
   output logic             pin_a_o,
   output logic             pin_a_oe_o,
   input  wire logic        pin_b_i,
   output logic             pin_b_o,
   output logic             pin_b_oe_o,
   input  wire logic        vector_page_i,
   output logic             done_pulse_o,
   output logic      [15:0] vector_addr_o,
   output logic      [15:0] macro_word_addr_o
);
   // ****************************************************
   // Registers and decode
   // ****************************************************
   logic [7:0]  mode_ff;
   logic [7:0]  shreg_ff;
   xfer_state_t state_ff;
   logic [2:0]  bit_cnt_ff;
   logic        so_ff;
   logic        rx_prev_ff;
   logic        pend_ff;
   logic        rel_ff, cmd_ff, ack_seen_ff, done_ff;
   logic        ack_en_ff, busy_en_ff, hold_low_ff, busy_hold_ff;
   logic        line_prev_ff, sck_prev_ff;
   logic        addr_xfer_ff;
   logic        acc, wr, wr_mode, wr_data, wr_bus, rd_data;
   logic        tx_en, rx_en, two_wire, lsb_first;
   clk_sel_t    clk_sel;
   sclk_if      sc ();

   assign acc       = cyc_i && stb_i && ack_o;
   assign wr        = acc && we_i && sel_i[0];
   assign wr_mode   = wr && (adr_i == `MODE_CTRL_ADDR);
   assign wr_data   = wr && (adr_i == `SHIFT_DATA_ADDR);
   assign wr_bus    = wr && (adr_i == `BUS_CTRL_ADDR);
   assign rd_data   = acc && !we_i && (adr_i == `SHIFT_DATA_ADDR);
   assign tx_en     = mode_ff[`BIT_TX_EN];
   assign rx_en     = mode_ff[`BIT_RX_EN];
   assign clk_sel   = clk_sel_t'(mode_ff[1:0]);
   assign two_wire  = mode_ff[`BIT_MODE_HI] && !mode_ff[`BIT_MODE_LO];
   assign lsb_first = !mode_ff[`BIT_MODE_HI] && mode_ff[`BIT_MODE_LO];

   // Ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   // Read mux, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (cyc_i && stb_i && !ack_o) begin
         if (adr_i == `MODE_CTRL_ADDR) begin
            dat_o <= {24'h00_0000, mode_ff};
         end else if (adr_i == `SHIFT_DATA_ADDR) begin
            dat_o <= {24'h00_0000, shreg_ff};
         end else if (adr_i == `BUS_CTRL_ADDR) begin
            dat_o <= {23'h00_0000, line_prev_ff, busy_en_ff, done_ff, ack_seen_ff,
                      ack_en_ff, cmd_ff, rel_ff, 2'b00};
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

   // Mode register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= `MODE_CTRL_RESET;
      end else if (wr_mode) begin
         mode_ff <= dat_i[7:0];
      end
   end

   // ****************************************************
   // Shift clock and line selection
   // ****************************************************
   logic sck_rise, sck_fall, sck_high, line_in, rx_bit, start_req, start_go, done_evt;
   logic ext_clk, low_req;

   sclk_gen u_sclk_gen (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .baud_tick_i (baud_tick_i),
      .sc          (sc.gen)
   );

   assign ext_clk  = (clk_sel == CLK_EXT);
   assign sc.sel   = clk_sel;
   assign sc.run   = (state_ff != ST_IDLE);
   // Edges of the chosen clock
   assign sck_rise = ext_clk ? (sck_i && !sck_prev_ff) : sc.rise;
   assign sck_fall = ext_clk ? (!sck_i && sck_prev_ff) : sc.fall;
   assign sck_high = ext_clk ? sck_i : sc.sck_lvl;
   // Pin choice counts only in two-wire mode
   assign line_in  = (two_wire && mode_ff[`BIT_PIN_CHOICE]) ? pin_b_i :
                     (two_wire ? pin_a_i : pin_b_i);
   assign rx_bit   = rx_en && line_in;
   assign done_evt = (state_ff == ST_SHIFT) && sck_rise && (bit_cnt_ff == `LAST_BIT);

   // Start sources of a byte
   assign start_req = (wr_data && tx_en)
                    || (wr_mode && dat_i[`BIT_RX_EN] && !rx_prev_ff
                        && !dat_i[`BIT_TX_EN])
                    || (rd_data && rx_en && !tx_en);
   // A low line from a busy slave holds the start back
   assign start_go  = (start_req || pend_ff) && (tx_en || rx_en)
                    && !(two_wire && !line_in && !low_req);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_prev_ff  <= 1'b1;
         line_prev_ff <= 1'b1;
         rx_prev_ff   <= 1'b0;
      end else begin
         sck_prev_ff  <= sck_i;
         line_prev_ff <= line_in;
         rx_prev_ff   <= wr_mode ? dat_i[`BIT_RX_EN] : rx_en;
      end
   end

   // Deferred start while the bus is busy, or until a receive enable lands
   always_ff @(posedge clk_i) begin
      if (rst_i || (!tx_en && !rx_en && !start_req)) begin
         pend_ff <= 1'b0;
      end else begin
         pend_ff <= (start_req || pend_ff) && !start_go && (state_ff == ST_IDLE);
      end
   end

   // ****************************************************
   // Shift engine
   // ****************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i || (!tx_en && !rx_en)) begin
         state_ff   <= ST_IDLE;
         bit_cnt_ff <= 3'h0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_go) begin
                  state_ff   <= ST_SHIFT;
                  bit_cnt_ff <= 3'h0;
               end
            end
            ST_SHIFT: begin
               if (sck_rise) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == `LAST_BIT) begin
                     state_ff <= two_wire ? ST_ACK : ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (sck_rise) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Shift register: load on write, sample on rising edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shreg_ff <= `SHIFT_RESET;
      end else if (wr_data) begin
         shreg_ff <= dat_i[7:0];
      end else if (state_ff == ST_SHIFT && sck_rise) begin
         shreg_ff <= lsb_first ? {rx_bit, shreg_ff[7:1]}
                               : {shreg_ff[6:0], rx_bit};
      end
   end

   // Serial output changes only on falling edges of a started byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         so_ff <= 1'b1;
      end else if (state_ff == ST_SHIFT && sck_fall && tx_en) begin
         so_ff <= lsb_first ? shreg_ff[0] : shreg_ff[7];
      end
   end

   // ****************************************************
   // Two-wire bus conditions and handshake
   // ****************************************************
   // Release and command detected while the clock is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rel_ff <= 1'b0;
         cmd_ff <= 1'b0;
      end else if (two_wire && sck_high && line_in && !line_prev_ff) begin
         rel_ff <= 1'b1;
         cmd_ff <= 1'b0;
      end else if (two_wire && sck_high && !line_in && line_prev_ff) begin
         cmd_ff <= 1'b1;
      end else if (done_evt) begin
         rel_ff <= 1'b0;
         cmd_ff <= 1'b0;
      end
   end

   // Byte class: address after release and command, else command or data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_xfer_ff <= 1'b0;
      end else if (state_ff == ST_IDLE && start_go) begin
         addr_xfer_ff <= rel_ff && cmd_ff;
      end
   end

   // Bus control bits written by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_en_ff   <= 1'b0;
         busy_en_ff  <= 1'b0;
         hold_low_ff <= 1'b0;
      end else if (wr_bus) begin
         ack_en_ff  <= dat_i[`BIT_ACK_EN];
         busy_en_ff <= dat_i[`BIT_BUSY_EN];
         if (dat_i[`BIT_CMD_TRIG]) begin
            hold_low_ff <= 1'b1;
         end else if (dat_i[`BIT_REL_TRIG]) begin
            hold_low_ff <= 1'b0;
         end
      end else if (state_ff == ST_IDLE && start_go) begin
         hold_low_ff <= 1'b0;
      end
   end

   // Busy after acknowledge until software writes new data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_hold_ff <= 1'b0;
      end else if (state_ff == ST_ACK && sck_rise && ack_en_ff && busy_en_ff) begin
         busy_hold_ff <= 1'b1;
      end else if (wr_data) begin
         busy_hold_ff <= 1'b0;
      end
   end

   // Acknowledge seen on the ninth rising edge; set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_seen_ff <= 1'b0;
      end else if (state_ff == ST_ACK && sck_rise && !line_in) begin
         ack_seen_ff <= 1'b1;
      end else if (wr_bus && dat_i[`BIT_ACK_SEEN]) begin
         ack_seen_ff <= 1'b0;
      end
   end

   // Transfer done flag; set beats clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_ff      <= 1'b0;
         done_pulse_o <= 1'b0;
      end else begin
         done_pulse_o <= done_evt && (!mode_ff[`BIT_WAKEUP]
                                      || (two_wire && addr_xfer_ff));
         if (done_evt && (!mode_ff[`BIT_WAKEUP] || (two_wire && addr_xfer_ff))) begin
            done_ff <= 1'b1;
         end else if (wr_bus && dat_i[`BIT_DONE_FLAG]) begin
            done_ff <= 1'b0;
         end
      end
   end

   // ****************************************************
   // Pin drivers
   // ****************************************************
   // Open-drain pull requests on the bus line
   assign low_req = hold_low_ff || busy_hold_ff
                  || (state_ff == ST_SHIFT && tx_en && !so_ff)
                  || (state_ff == ST_ACK && ack_en_ff && !tx_en);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_o      <= 1'b1;
         sck_oe_o   <= 1'b0;
         pin_a_o    <= 1'b1;
         pin_a_oe_o <= 1'b0;
         pin_b_o    <= 1'b1;
         pin_b_oe_o <= 1'b0;
      end else begin
         sck_o    <= sc.sck_lvl;
         sck_oe_o <= !ext_clk;
         if (two_wire) begin
            pin_a_o    <= 1'b0;
            pin_b_o    <= 1'b0;
            pin_a_oe_o <= low_req && !mode_ff[`BIT_PIN_CHOICE];
            pin_b_oe_o <= low_req && mode_ff[`BIT_PIN_CHOICE];
         end else begin
            pin_a_o    <= so_ff;
            pin_a_oe_o <= tx_en;
            pin_b_o    <= 1'b1;
            pin_b_oe_o <= 1'b0;
         end
      end
   end

   // Vector of the transfer-done interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_addr_o     <= `VEC_PAGE0;
         macro_word_addr_o <= `MACRO_WORD_ADDR;
      end else begin
         vector_addr_o     <= vector_page_i ? `VEC_PAGE1 : `VEC_PAGE0;
         macro_word_addr_o <= `MACRO_WORD_ADDR;
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

   property p_eighth_rise;
      @(posedge clk_i) disable iff (rst_i)
         (done_evt && tx_en && !two_wire) |=> (state_ff == ST_IDLE);
   endproperty
   a_eighth_rise: assert property (p_eighth_rise) else $error("no stop at eighth rise");

   property p_out_holds;
      @(posedge clk_i) disable iff (rst_i)
         (state_ff == ST_IDLE && !wr_data) |=> (so_ff == $past(so_ff));
   endproperty
   a_out_holds: assert property (p_out_holds) else $error("output moved while idle");

   property p_rx_rewrite;
      @(posedge clk_i) disable iff (rst_i)
         (wr_mode && rx_en && !tx_en && dat_i[`BIT_RX_EN] && !dat_i[`BIT_TX_EN]
          && state_ff == ST_IDLE && !pend_ff && !rd_data) |=> (state_ff == ST_IDLE);
   endproperty
   a_rx_rewrite: assert property (p_rx_rewrite) else $error("rewrite of rx enable started");

   property p_counter_clear;
      @(posedge clk_i) disable iff (rst_i)
         (!tx_en && !rx_en) |=> (bit_cnt_ff == 3'h0 && state_ff == ST_IDLE);
   endproperty
   a_counter_clear: assert property (p_counter_clear) else $error("counter not cleared");

   property p_open_drain;
      @(posedge clk_i) disable iff (rst_i)
         (two_wire && $past(two_wire)) |-> !(pin_a_oe_o && pin_a_o) && !(pin_b_oe_o && pin_b_o);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("bus pin driven high");

   property p_clk_dir;
      @(posedge clk_i) disable iff (rst_i) ext_clk |=> !sck_oe_o;
   endproperty
   a_clk_dir: assert property (p_clk_dir) else $error("clock pin driven in external mode");

   property p_vector;
      @(posedge clk_i) disable iff (rst_i)
         vector_page_i |=> (vector_addr_o == `VEC_PAGE1);
   endproperty
   a_vector: assert property (p_vector) else $error("wrong vector page");

   property p_release_seen;
      @(posedge clk_i) disable iff (rst_i)
         (two_wire && sck_high && line_in && !line_prev_ff) |=> rel_ff && !cmd_ff;
   endproperty
   a_release_seen: assert property (p_release_seen) else $error("release missed");
endmodule : csi_top

// file: design/sclk_gen.sv
// Internal shift clock generator with edge pulses
`timescale 1ns/1ps
`include "csi_regs.svh"
module sclk_gen
   import csi_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic baud_tick_i,
   sclk_if.gen       sc
);
   logic [4:0] cnt_ff;
   logic [4:0] half;
   logic       tick;

   // Half period choice and toggle moment
   always_comb begin
      half = (sc.sel == CLK_DIV32) ? `DIV32_HALF : `DIV8_HALF;
      tick = (sc.sel == CLK_BAUD) ? baud_tick_i : (cnt_ff == half);
   end

   // Clock idles high; first edge of a run is falling
   always_ff @(posedge clk_i) begin
      if (rst_i || !sc.run || sc.sel == CLK_EXT) begin
         cnt_ff     <= 5'h00;
         sc.sck_lvl <= 1'b1;
         sc.rise    <= 1'b0;
         sc.fall    <= 1'b0;
      end else if (tick) begin
         cnt_ff     <= 5'h00;
         sc.sck_lvl <= ~sc.sck_lvl;
         sc.rise    <= ~sc.sck_lvl;
         sc.fall    <= sc.sck_lvl;
      end else begin
         cnt_ff     <= cnt_ff + 5'h01;
         sc.rise    <= 1'b0;
         sc.fall    <= 1'b0;
      end
   end
endmodule : sclk_gen

// file: design/sclk_if.sv
// Link between the shift engine and the shift clock generator
`timescale 1ns/1ps
interface sclk_if;
   import csi_pkg::*;
   logic     run;
   clk_sel_t sel;
   logic     sck_lvl;
   logic     rise;
   logic     fall;
   modport gen  (input run, input sel, output sck_lvl, output rise, output fall);
   modport user (output run, output sel, input sck_lvl, input rise, input fall);
endinterface : sclk_if

// file: testbench/serial_peer.sv
// Far-side serial peripheral model: MSB first, can make its own shift clock
`timescale 1ns/1ps
module serial_peer (
   input  wire logic       clk_i,
   input  wire logic       sck_i,
   input  wire logic       so_i,
   input  wire logic       load_i,
   input  wire logic [7:0] tx_i,
   input  wire logic       gen_i,
   input  wire logic [3:0] gen_n_i,
   output logic            sck_o,
   output logic            si_o,
   output logic [7:0]      rx_o
);
   logic [7:0] sh = 8'h00;
   logic [3:0] left = 4'h0;
   logic [3:0] half = 4'h0;
   initial sck_o = 1'b1;
   initial si_o = 1'b1;
   initial rx_o = 8'h00;
   // Own clock, ten cycles a phase, stands high between frames
   always @(posedge clk_i) begin
      if (left == 4'h0) begin
         if (gen_i) left <= gen_n_i;
      end else if (half == 4'h9) begin
         half  <= 4'h0;
         sck_o <= ~sck_o;
         if (!sck_o) left <= left - 4'h1;
      end else half <= half + 4'h1;
   end
   // Next bit out on the falling edge
   always @(negedge sck_i or posedge load_i) begin
      if (load_i) sh <= tx_i;
      else begin
         si_o <= sh[7];
         sh   <= {sh[6:0], ~sh[0]};
      end
   end
   // Incoming bit taken on the rising edge
   always @(posedge sck_i) rx_o <= {rx_o[6:0], so_i};
endmodule : serial_peer

// file: testbench/testbench.sv
// Self-checking bench of the clocked serial port
`timescale 1ns/1ps
`include "csi_regs.svh"
module testbench;
   logic        clk_i, sck, sck_oe, done, ack, pa_o, pa_oe, pb_o, pb_oe, p_sck, p_si;
   logic        rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, baud = 1'b0, vpage = 1'b0;
   logic        load = 1'b0, gen = 1'b0, two = 1'b0, pick = 1'b0, ackp = 1'b0;
   logic [15:0] adr = 16'h0000, vec, mword;
   logic [31:0] wdat = 32'h0, rdat, q, last;
   logic [3:0]  sel = 4'h0, gen_n = 4'h0;
   logic [7:0]  ptx = 8'h00, prx, b, c;
   logic [1:0]  hold;
   logic [7:0]  modes [5] = '{8'hc3, 8'hc7, 8'hc2, 8'hc1, 8'hcf};
   int          mismatches = 0, comparisons = 0, i, h, span, seed;
   wire         sck_line = sck_oe ? sck : p_sck;
   wire         a_line = pa_oe ? pa_o : !(ackp && !pick);
   wire         b_line = pb_oe ? pb_o : (two ? !(ackp && pick) : p_si);
   csi_top csi_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
      .dat_o(rdat), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
      .baud_tick_i(baud), .sck_i(sck_line), .sck_o(sck), .sck_oe_o(sck_oe),
      .pin_a_i(a_line), .pin_a_o(pa_o), .pin_a_oe_o(pa_oe), .pin_b_i(b_line),
      .pin_b_o(pb_o), .pin_b_oe_o(pb_oe), .vector_page_i(vpage), .done_pulse_o(done),
      .vector_addr_o(vec), .macro_word_addr_o(mword));
   serial_peer serial_peer_inst (.clk_i(clk_i), .sck_i(sck_line), .so_i(a_line),
      .load_i(load), .tx_i(ptx), .gen_i(gen), .gen_n_i(gen_n), .sck_o(p_sck),
      .si_o(p_si), .rx_o(prx));
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Random baud ticks
   always @(posedge clk_i) baud <= ($urandom % 4) == 0;
   // Two-wire pins: other pin silent, bus pin only pulls low
   always @(posedge clk_i) if (two) chk({pick ? pa_oe : pb_oe, pick ? pb_oe & pb_o : pa_oe & pa_o}, 0);
   task automatic test_done;
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One classic bus cycle, held until ack
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 64);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         mismatches++;
         test_done();
      end
   endtask : wb
   task automatic pl(input logic [7:0] v);
      ptx  <= v;
      load <= 1'b1;
      @(posedge clk_i);
      load <= 1'b0;
   endtask : pl
   // Peer clocks n periods (n=0: own clock), counts done pulses
   task automatic frame(input logic [3:0] n, input int exp, input int lim);
      int k;
      int seen;
      seen = 0;
      if (n != 4'h0) begin
         lim = 20 * n + 40;
         gen_n <= n;
         gen   <= 1'b1;
         @(posedge clk_i);
         gen <= 1'b0;
      end
      for (k = 0; k < lim; k++) begin
         @(posedge clk_i);
         if (done === 1'b1) seen++;
         if (n == 4'h0 && seen > 0) break;
      end
      span = k;
      chk(seen, exp);
      if (n == 4'h0 && exp > 0 && seen == 0) test_done();
   endtask : frame
   task automatic two_mode(input logic [7:0] m);
      two <= 1'b0;
      wb(1, `MODE_CTRL_ADDR, {24'h0, m});
      repeat (2) @(posedge clk_i);
      pick <= m[4];
      two  <= 1'b1;
   endtask : two_mode
   function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
      ord = v;
      if (lsb) for (int j = 0; j < 8; j++) ord[j] = v[7 - j];
   endfunction : ord
   // Main sequence
   initial begin
      seed = $urandom(32'h0629);
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, `MODE_CTRL_ADDR, 0);
      chk(q, 32'h0);
      wb(0, 16'hff90, 0);
      chk(q, 32'h0);
      chk({mword, sck_oe, sck}, {16'hfe22, 2'b01});
      repeat (4) begin
         b = 8'($urandom);
         vpage <= b[0];
         repeat (2) @(posedge clk_i);
         chk(vec, b[0] ? 16'h8022 : 16'h0022);
      end
      // Internal clock duplex, every clock choice and bit order
      for (i = 0; i < 5; i++) begin
         wb(1, `MODE_CTRL_ADDR, {24'h0, modes[i]});
         b = 8'($urandom);
         c = 8'($urandom);
         pl(c);
         wb(1, `SHIFT_DATA_ADDR, {24'h0, b});
         chk(sck_oe, 1);
         frame(0, 1, 3000);
         h = (modes[i][1:0] == 2'b10) ? 16 : 4;
         if (modes[i][1]) chk(span >= 15 * h && span <= 16 * h + 10, 1);
         wb(0, `SHIFT_DATA_ADDR, 0);
         last = q;
         chk(q, ord(c, modes[i][3:2] == 2'b01));
         chk(prx, ord(b, modes[i][3:2] == 2'b01));
      end
      // External clock: nothing started holds the output, then receive starts by enable and a duplex byte
      wb(1, `MODE_CTRL_ADDR, 32'hc0);
      hold = {pa_oe, pa_o};
      frame(8, 0, 0);
      chk({pa_oe, pa_o}, hold);
      wb(0, `SHIFT_DATA_ADDR, 0);
      chk(q, last);
      wb(1, `MODE_CTRL_ADDR, 0);
      c = 8'($urandom);
      pl(c);
      wb(1, `MODE_CTRL_ADDR, 32'h40);
      frame(8, 1, 0);
      wb(1, `MODE_CTRL_ADDR, 32'h40);
      pl(~c);
      frame(8, 0, 0);
      wb(0, `SHIFT_DATA_ADDR, 0);
      chk(q, {24'h0, c});
      frame(3, 0, 0);
      wb(1, `MODE_CTRL_ADDR, 0);
      wb(1, `MODE_CTRL_ADDR, 32'hc0);
      b = 8'($urandom);
      c = 8'($urandom);
      pl(c);
      wb(1, `SHIFT_DATA_ADDR, {24'h0, b});
      frame(8, 1, 0);
      wb(0, `SHIFT_DATA_ADDR, 0);
      chk({q[23:0], prx}, {16'h0000, c, b});
      // Two-wire bus on each pin: command, release, data byte
      for (i = 0; i < 2; i++) begin
         two_mode(i ? 8'hdb : 8'hcb);
         wb(1, `BUS_CTRL_ADDR, 32'h2);
         repeat (2) @(posedge clk_i);
         wb(0, `BUS_CTRL_ADDR, 0);
         chk({q[8], q[3]}, 2'b01);
         wb(1, `BUS_CTRL_ADDR, 32'h21);
         repeat (2) @(posedge clk_i);
         wb(0, `BUS_CTRL_ADDR, 0);
         chk({q[8], q[5], q[2]}, 3'b101);
         b = 8'($urandom);
         wb(1, `SHIFT_DATA_ADDR, {24'h0, b});
         frame(0, 1, 400);
         // Peer acknowledges, then holds the line low as busy
         ackp <= 1'b1;
         wb(0, `SHIFT_DATA_ADDR, 0);
         chk(q, {24'h0, b});
         repeat (6) @(posedge clk_i);
         wb(1, `SHIFT_DATA_ADDR, {24'h0, ~b});
         frame(0, 0, 100);
         ackp <= 1'b0;
         frame(0, 1, 400);
         wb(0, `BUS_CTRL_ADDR, 0);
         chk(q[5], 1'b1);
      end
      // Wakeup: plain data ignored, address after release and command counts
      two_mode(8'heb);
      wb(1, `SHIFT_DATA_ADDR, {24'h0, b});
      frame(0, 0, 400);
      wb(1, `BUS_CTRL_ADDR, 32'h2);
      wb(1, `BUS_CTRL_ADDR, 32'h1);
      wb(1, `BUS_CTRL_ADDR, 32'h2);
      // Last address bit high, so the line stays up through the ack clock
      c[0] = 1'b1;
      wb(1, `SHIFT_DATA_ADDR, {24'h0, c});
      frame(0, 1, 400);
      repeat (12) @(posedge clk_i);
      // Command byte: command condition only, no release
      wb(1, `BUS_CTRL_ADDR, 32'h2);
      wb(1, `SHIFT_DATA_ADDR, {24'h0, b});
      frame(0, 0, 400);
      test_done();
   end
endmodule : testbench
